// ==== rtl/sync_serial_pkg.sv ====
package sync_serial_pkg;

  // Mode field codes
  localparam logic [3:0] MODE_MASTER_DIV4   = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16  = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64  = 4'h2;
  localparam logic [3:0] MODE_MASTER_TIMER  = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SELECT  = 4'h4;
  localparam logic [3:0] MODE_SLAVE_FREE    = 4'h5;
  localparam logic [3:0] MODE_MASTER_DIV8   = 4'hA;

  // Half-bit time in system clocks, less one, for each oscillator divider
  localparam logic [4:0] HALF_DIV4  = 5'h01;
  localparam logic [4:0] HALF_DIV8  = 5'h03;
  localparam logic [4:0] HALF_DIV16 = 5'h07;
  localparam logic [4:0] HALF_DIV64 = 5'h1F;

  localparam logic [2:0] LAST_BIT    = 3'h7;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  typedef struct packed {
    logic       port_enable_bit;
    logic       clock_idle_polarity;
    logic       clock_edge_select;
    logic       input_sample_phase;
    logic [3:0] port_mode_field;
  } port_config_t;

  typedef struct packed {
    logic write_collision_flag;
    logic receive_overflow_flag;
    logic buffer_full_flag;
    logic port_interrupt_flag;
  } port_status_t;

  typedef struct packed {
    logic serial_data_out;
    logic serial_data_out_oe;
    logic serial_clock_out;
    logic serial_clock_oe;
  } pin_drive_t;

endpackage

// ==== rtl/sync_serial_spi_port.sv ====
// What this block does
// R01 - Pins are taken by the port only while the enable bit is set.
// R02 - Clearing enable, reconfiguring, then setting enable restarts the port cleanly.
// R03 - Data-in and select are inputs, data-out output, clock follows master/slave.
// R04 - In master mode a buffer write starts one byte transfer at once.
// R05 - Master receive-only still shifts in and loads buffer with flags.
// R06 - Bytes shift most significant bit first.
// R07 - Master clock is oscillator over 4, 8, 16, 64, or timer tick over two.
// R08 - With edge select set, first data bit is valid before first clock edge.
// R09 - Slave shifts one bit per external pulse, flags after last bit.
// R10 - Slave keeps working during sleep and can request wake-up.
// R11 - Mode 04h: low select enables shifting and drives data-out.
// R12 - Select high in mode 04h floats data-out even mid-byte.
// R13 - Select high in mode 04h or enable cleared zeroes the bit counter.
// R14 - Slave with edge select set needs select control enabled.
// R15 - Both ends share idle polarity; shift out one edge, sample other.
// R16 - Master freezes during sleep and resumes afterwards.
// R17 - Master byte completion raises an interrupt able to wake the device.
// R18 - Slave shifter runs from the external clock; 8 bits set the flag.
// R19 - Device reset disables the port and aborts any transfer.
// R20 - SPI modes map: 0,0=P0E1; 0,1=P0E0; 1,0=P1E1; 1,1=P1E0.
// R21 - Data-out configured as input is never driven.
// R22 - Buffer write during transfer is dropped and sets write collision.
// R23 - Buffer full sets on receive, clears on buffer read.
// R24 - Mode codes 0101, 0100 slave, 1010 master at oscillator over eight.
// R25 - Sample phase picks middle or end of data output time in master.
// R26 - Master clock idles at polarity level with eight pulses per byte.
`timescale 1ns/1ps
module sync_serial_spi_port
  import sync_serial_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire port_config_t port_config,
  input  wire logic         data_out_is_input,
  input  wire logic         sleep_mode,
  input  wire logic         timer_two_tick,
  input  wire logic         buffer_write,
  input  wire logic [7:0]   buffer_write_data,
  input  wire logic         buffer_read,
  input  wire logic         clear_write_collision,
  input  wire logic         clear_overflow,
  input  wire logic         clear_interrupt_flag,
  input  wire logic         serial_data_in,
  input  wire logic         serial_clock_in,
  input  wire logic         slave_select_n,
  output logic [7:0]        transfer_buffer,
  output port_status_t      port_status,
  output logic              transfer_busy,
  output logic              wake_request,
  output pin_drive_t        pin_drive
);

  logic       is_master;
  logic       is_slave;
  logic       select_ctl;
  logic       slave_active;
  logic [4:0] half_limit;
  logic       rate_tick;

  always_comb begin
    is_master  = 1'b0;
    half_limit = HALF_DIV4;
    // R24 mode decode
    case (port_config.port_mode_field)
      MODE_MASTER_DIV4: begin
        is_master  = 1'b1;
        half_limit = HALF_DIV4;
      end
      // R07 rate choice
      MODE_MASTER_DIV16: begin
        is_master  = 1'b1;
        half_limit = HALF_DIV16;
      end
      MODE_MASTER_DIV64: begin
        is_master  = 1'b1;
        half_limit = HALF_DIV64;
      end
      MODE_MASTER_TIMER: begin
        is_master  = 1'b1;
        half_limit = BYTE_RESET[4:0];
      end
      MODE_MASTER_DIV8: begin
        is_master  = 1'b1;
        half_limit = HALF_DIV8;
      end
      default: begin
        is_master  = 1'b0;
        half_limit = HALF_DIV4;
      end
    endcase
    is_slave   = (port_config.port_mode_field == MODE_SLAVE_SELECT) ||
                 (port_config.port_mode_field == MODE_SLAVE_FREE);
    select_ctl = port_config.port_mode_field == MODE_SLAVE_SELECT;
    // R11 select gating
    slave_active = is_slave && !(select_ctl && slave_select_n);
  end

  typedef enum {ST_IDLE, ST_LEAD, ST_TRAIL} state_t;

  state_t       state;
  state_t       next_state;
  logic [4:0]   div_count;
  logic [4:0]   next_div_count;
  logic [2:0]   bit_count;
  logic [2:0]   next_bit_count;
  logic [7:0]   shift_reg;
  logic [7:0]   next_shift_reg;
  logic [7:0]   next_buffer;
  port_status_t next_status;
  logic         sck_level;
  logic         next_sck_level;
  logic         sck_prev;
  logic         next_sck_prev;
  logic         sample_bit;
  logic         next_sample_bit;
  logic         slave_started;
  logic         next_slave_started;
  logic         wake_pulse;
  pin_drive_t   next_pins;

  // Outputs registered: sampled data-in held until shift
  always_comb begin
    logic byte_done;
    logic sck_edge;
    logic lead_edge;
    logic shift_edge;
    logic sample_edge;
    logic pin_level;
    logic collide;
    byte_done          = 1'b0;
    collide            = 1'b0;
    next_state         = state;
    next_div_count     = div_count;
    next_bit_count     = bit_count;
    next_shift_reg     = shift_reg;
    next_buffer        = transfer_buffer;
    next_status        = port_status;
    next_sck_level     = sck_level;
    next_sck_prev      = serial_clock_in;
    next_sample_bit    = sample_bit;
    next_slave_started = slave_started;
    // R07 timer rate is one half period per tick
    rate_tick = (port_config.port_mode_field == MODE_MASTER_TIMER) ? timer_two_tick
              : (div_count == half_limit);
    // R15 leading edge leaves idle level
    pin_level   = serial_clock_in;
    sck_edge    = pin_level != sck_prev;
    lead_edge   = sck_edge && (pin_level != port_config.clock_idle_polarity);
    // R20 edge select: set means shift on return to idle
    shift_edge  = port_config.clock_edge_select ? (sck_edge && !lead_edge) : lead_edge;
    sample_edge = port_config.clock_edge_select ? lead_edge : (sck_edge && !lead_edge);

    if (!port_config.port_enable_bit) begin
      // R02 disable resets port; R13 counter cleared
      next_state         = ST_IDLE;
      next_bit_count     = BYTE_RESET[2:0];
      next_div_count     = BYTE_RESET[4:0];
      next_sck_level     = port_config.clock_idle_polarity;
      next_slave_started = 1'b0;
    end else if (is_master) begin
      // R16 sleep freezes master clocks
      if (!sleep_mode) begin
        case (state)
          ST_IDLE: begin
            // R26 idle level
            next_sck_level = port_config.clock_idle_polarity;
            next_div_count = BYTE_RESET[4:0];
          end
          ST_LEAD: begin
            next_div_count = rate_tick ? BYTE_RESET[4:0] : div_count + 5'h01;
            if (rate_tick) begin
              next_sck_level = ~sck_level;
              next_state     = ST_TRAIL;
              // R25 middle sample
              if (!port_config.input_sample_phase) begin
                next_sample_bit = serial_data_in;
              end
              if (!port_config.clock_edge_select && bit_count != BYTE_RESET[2:0]) begin
                next_shift_reg = {shift_reg[6:0], sample_bit};
              end
            end
          end
          ST_TRAIL: begin
            next_div_count = rate_tick ? BYTE_RESET[4:0] : div_count + 5'h01;
            if (rate_tick) begin
              next_sck_level = port_config.clock_idle_polarity;
              // R25 end sample
              if (port_config.input_sample_phase) begin
                next_sample_bit = serial_data_in;
              end
              next_bit_count = bit_count + 3'h1;
              if (bit_count == LAST_BIT) begin
                byte_done = 1'b1;
                next_state = ST_IDLE;
              end else begin
                next_state = ST_LEAD;
                // R06 shift msb first
                if (port_config.clock_edge_select) begin
                  next_shift_reg = {shift_reg[6:0], port_config.input_sample_phase ?
                                    serial_data_in : sample_bit};
                end
              end
            end
          end
          default: next_state = ST_IDLE;
        endcase
      end
    end else if (is_slave) begin
      // R13 select high resets counter
      if (!slave_active) begin
        next_bit_count     = BYTE_RESET[2:0];
        next_slave_started = 1'b0;
      end else begin
        // R09 R18 one bit per external pulse, works in sleep
        if (sample_edge) begin
          next_sample_bit    = serial_data_in;
          next_slave_started = 1'b1;
          next_bit_count     = bit_count + 3'h1;
          if (bit_count == LAST_BIT) begin
            byte_done = 1'b1;
          end
        end
        if (shift_edge && slave_started) begin
          next_shift_reg = {shift_reg[6:0], sample_bit};
        end
        if (byte_done) begin
          next_slave_started = 1'b0;
        end
      end
    end

    // R05 received byte to buffer
    if (byte_done) begin
      next_buffer = is_master && !port_config.input_sample_phase ?
                    {shift_reg[6:0], sample_bit} : {shift_reg[6:0], serial_data_in};
      next_shift_reg = next_buffer;
      // R23 buffer full on receive
      next_status.buffer_full_flag    = 1'b1;
      next_status.port_interrupt_flag = 1'b1;
      if (is_slave && port_status.buffer_full_flag && !buffer_read) begin
        next_status.receive_overflow_flag = 1'b1;
        next_buffer = transfer_buffer;
      end
    end else if (buffer_read) begin
      next_status.buffer_full_flag = 1'b0;
    end

    if (buffer_write && port_config.port_enable_bit) begin
      // R22 collision when busy
      if (state != ST_IDLE || (is_slave && bit_count != BYTE_RESET[2:0])) begin
        collide                          = 1'b1;
        next_status.write_collision_flag = 1'b1;
      end else begin
        next_shift_reg = buffer_write_data;
        next_buffer    = buffer_write_data;
        // R04 start on write
        if (is_master) begin
          next_state     = ST_LEAD;
          next_bit_count = BYTE_RESET[2:0];
          next_div_count = BYTE_RESET[4:0];
        end
      end
    end

    // Set wins over clear
    if (clear_write_collision && !collide) begin
      next_status.write_collision_flag = 1'b0;
    end
    if (clear_overflow && !byte_done) begin
      next_status.receive_overflow_flag = 1'b0;
    end
    if (clear_interrupt_flag && !byte_done) begin
      next_status.port_interrupt_flag = 1'b0;
    end
    // R17 R10 wake on completed byte
    wake_pulse = byte_done;

    // R01 R03 pin ownership
    next_pins.serial_clock_oe    = port_config.port_enable_bit && is_master;
    next_pins.serial_clock_out   = next_sck_level;
    // R08 data valid before first edge comes from msb of loaded shifter
    next_pins.serial_data_out    = next_shift_reg[7];
    // R21 R12 R14 data-out drive gating
    next_pins.serial_data_out_oe = port_config.port_enable_bit && !data_out_is_input &&
                                   (is_master || (slave_active &&
                                   !(port_config.clock_edge_select && !select_ctl)));
  end

  // R19 reset disables and aborts
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state           <= ST_IDLE;
      div_count       <= BYTE_RESET[4:0];
      bit_count       <= BYTE_RESET[2:0];
      shift_reg       <= BYTE_RESET;
      transfer_buffer <= BYTE_RESET;
      port_status     <= '0;
      sck_level       <= 1'b0;
      sck_prev        <= 1'b0;
      sample_bit      <= 1'b0;
      slave_started   <= 1'b0;
      transfer_busy   <= 1'b0;
      wake_request    <= 1'b0;
      pin_drive       <= '0;
    end else begin
      state           <= next_state;
      div_count       <= next_div_count;
      bit_count       <= next_bit_count;
      shift_reg       <= next_shift_reg;
      transfer_buffer <= next_buffer;
      port_status     <= next_status;
      sck_level       <= next_sck_level;
      sck_prev        <= next_sck_prev;
      sample_bit      <= next_sample_bit;
      slave_started   <= next_slave_started;
      transfer_busy   <= next_state != ST_IDLE;
      wake_request    <= wake_pulse;
      pin_drive       <= next_pins;
    end
  end

endmodule

// ==== verification/spi_peer_model.sv ====
`timescale 1ns/1ps
module spi_peer_model (
  input  wire logic       sck,
  input  wire logic       cpol,
  input  wire logic       sel,
  input  wire logic       mosi,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  logic [7:0] shift;
  wire        lead = sck ^ cpol;
  always @(posedge sel) shift = tx;
  always @(negedge lead) if (sel) shift = {shift[6:0], 1'b0};
  always @(posedge lead) if (sel) rx = {rx[6:0], mosi};
  // Released line shows the inverse so a stale sample cannot pass
  assign miso = sel ? shift[7] : ~shift[7];
endmodule

// ==== verification/sync_serial_spi_port_assertions.sv ====
`timescale 1ns/1ps
module sync_serial_spi_port_assertions
  import sync_serial_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         reset,
  input wire port_config_t port_config,
  input wire logic         data_out_is_input,
  input wire logic         sleep_mode,
  input wire logic         buffer_write,
  input wire logic         slave_select_n,
  input wire logic         transfer_busy,
  input wire logic         wake_request,
  input wire port_status_t port_status,
  input wire pin_drive_t   pin_drive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic en;
  logic mst;
  assign en  = port_config.port_enable_bit;
  assign mst = en && (port_config.port_mode_field inside {MODE_MASTER_DIV4, MODE_MASTER_DIV16,
               MODE_MASTER_DIV64, MODE_MASTER_TIMER, MODE_MASTER_DIV8});
  sequence byte_done;
    $fell(transfer_busy) ##0 en;
  endsequence
  off_pins_a: assert property ((!en)[*2] |-> !pin_drive.serial_data_out_oe &&
    !pin_drive.serial_clock_oe) else $error("pins driven while disabled");
  sdo_input_a: assert property (data_out_is_input[*2] |-> !pin_drive.serial_data_out_oe)
    else $error("data-out driven as input");
  slave_clock_a: assert property ((en && !mst)[*2] |-> !pin_drive.serial_clock_oe)
    else $error("clock driven in slave mode");
  select_float_a: assert property ((en && port_config.port_mode_field == MODE_SLAVE_SELECT &&
    slave_select_n)[*3] |-> !pin_drive.serial_data_out_oe) else $error("data-out not floated");
  master_start_a: assert property (buffer_write && !transfer_busy && mst && !sleep_mode
    |=> transfer_busy) else $error("write did not start transfer");
  write_coll_a: assert property (buffer_write && transfer_busy && en
    |=> port_status.write_collision_flag) else $error("collision not flagged");
  done_flags_a: assert property (byte_done |-> ##[0:2] port_status.port_interrupt_flag)
    else $error("byte end without flag");
  wake_pulse_a: assert property (wake_request |=> !wake_request)
    else $error("wake longer than one cycle");
  clock_idle_a: assert property ((mst && !transfer_busy && $stable(port_config))[*3]
    |-> pin_drive.serial_clock_out == port_config.clock_idle_polarity)
    else $error("clock not at idle level");
  sleep_hold_a: assert property ((sleep_mode && transfer_busy)[*3]
    |-> $stable(pin_drive) && transfer_busy) else $error("transfer moved in sleep");
endmodule
bind sync_serial_spi_port sync_serial_spi_port_assertions i_chk (.clk_sys, .reset, .port_config,
  .data_out_is_input, .sleep_mode, .buffer_write, .slave_select_n, .transfer_busy,
  .wake_request, .port_status, .pin_drive);

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import sync_serial_pkg::*;
  logic         clk_sys, reset, dii, slp, tick, bw, br, cwc, cif, sdi, sck, ssn, psel, busy;
  logic         wake, miso;
  logic [1:0]   tc = 2'h0;
  logic [7:0]   bwd, ptx, prx, tbuf;
  port_config_t cfg;
  port_status_t st;
  pin_drive_t   pd;
  int           error_cnt, total_checks, wk, n, s;
  logic [3:0]   md [5] = '{MODE_MASTER_DIV4, MODE_MASTER_DIV16, MODE_MASTER_DIV64,
                           MODE_MASTER_TIMER, MODE_MASTER_DIV8};
  int           hp [5] = '{2, 8, 32, 4, 4};
  sync_serial_spi_port i_dut (.clk_sys, .reset, .port_config(cfg), .data_out_is_input(dii),
    .sleep_mode(slp), .timer_two_tick(tick), .buffer_write(bw), .buffer_write_data(bwd),
    .buffer_read(br), .clear_write_collision(cwc), .clear_overflow(1'b0),
    .clear_interrupt_flag(cif), .serial_data_in(cfg.port_mode_field[2] ? sdi : miso),
    .serial_clock_in(sck), .slave_select_n(ssn), .transfer_buffer(tbuf), .port_status(st),
    .transfer_busy(busy), .wake_request(wake), .pin_drive(pd));
  spi_peer_model i_peer (.sck(pd.serial_clock_oe ? pd.serial_clock_out : cfg.clock_idle_polarity),
    .cpol(cfg.clock_idle_polarity), .sel(psel), .mosi(pd.serial_data_out), .tx(ptx), .miso,
    .rx(prx));
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    tc <= tc + 2'h1;
    tick <= (tc == 2'h3);
  end
  always @(posedge clk_sys) if (wake === 1'b1) wk++;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // Enable drops before fields change, as reconfiguration requires
  task automatic setcfg(input logic [3:0] m, input logic p);
    cfg.port_enable_bit = 0;
    cyc(2);
    cfg = '{1'b0, p, 1'b1, m == MODE_MASTER_DIV8, m};
    cyc(1);
    cfg.port_enable_bit = 1;
    cyc(3);
  endtask
  task automatic xfer(input logic [7:0] w, input logic [7:0] r, input logic col, input int sl);
    ptx = r;
    psel = 1;
    bwd = w;
    bw = 1;
    cyc(1);
    bw = 0;
    cyc(1);
    n = 2;
    while (busy !== 1'b0 && n < 3000) begin
      cyc(1);
      n++;
      bw = (n == 6) && col;
      if (n == 6) bwd = ~w;
      if (n == 20) slp = (sl != 0);
      if (n == 20 + sl) slp = 0;
    end
    if (n == 3000) begin
      error_cnt++;
      conclude();
    end
    psel = 0;
  endtask
  task automatic sbits(input logic [7:0] v, input int k);
    for (int b = 7; b > 7 - k; b--) begin
      sdi = v[b];
      cyc(4);
      sck = 1;
      cyc(4);
      sck = 0;
    end
  endtask
  initial begin
    {reset, dii, slp, bw, br, cwc, cif, sdi, sck, psel, bwd, ptx} = '0;
    cfg = '0;
    ssn = 1;
    reset = 1;
    cyc(5);
    reset = 0;
    cyc(2);
    check(pd, 4'h0);
    for (int i = 0; i < 5; i++) begin
      setcfg(md[i], i[0]);
      s = (i == 2) ? 100 : 0;
      check(pd.serial_clock_out, i[0]);
      xfer(8'hA5 ^ i[7:0], 8'h3C + i[7:0], i == 1, s);
      cyc(3);
      check(prx, 8'hA5 ^ i[7:0]);
      check(tbuf, 8'h3C + i[7:0]);
      check(st, {i == 1, 3'b011});
      check(n >= 16 * hp[i] + s - 2 && n <= 16 * hp[i] + s + 8, 1);
      {br, cwc, cif} = 3'b111;
      cyc(1);
      {br, cwc, cif} = 3'b000;
      cyc(1);
      check(st, 4'h0);
    end
    dii = 1;
    cyc(2);
    check(pd.serial_data_out_oe, 0);
    dii = 0;
    setcfg(MODE_SLAVE_SELECT, 0);
    slp = 1;
    check(pd.serial_data_out_oe, 0);
    ssn = 0;
    cyc(3);
    check(pd.serial_data_out_oe, 1);
    sbits(8'hFF, 3);
    ssn = 1;
    cyc(3);
    ssn = 0;
    cyc(3);
    sbits(8'h96, 8);
    cyc(4);
    check(tbuf, 8'h96);
    check(st, 4'h3);
    check(wk, 6);
    // Unread buffer: next byte sets overflow and the old byte stays
    sbits(8'h5A, 8);
    cyc(4);
    check(tbuf, 8'h96);
    check(st, 4'h7);
    check(wk, 7);
    slp = 0;
    ssn = 1;
    setcfg(MODE_MASTER_DIV16, 0);
    bw = 1;
    cyc(1);
    bw = 0;
    cyc(10);
    reset = 1;
    cyc(1);
    check({busy, pd}, 5'h00);
    reset = 0;
    cyc(20);
    check(busy, 0);
    conclude();
  end
endmodule
